//--- hw/adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// register addresses (3-bit plain port)
`define ADDR_CHAN_REF_SEL      3'h0
`define ADDR_CTRL_STATUS       3'h1
`define ADDR_RESULT_LOW        3'h2
`define ADDR_RESULT_HIGH       3'h3
`define ADDR_TRIG_CONFIG       3'h4

// channel_reference_select fields
`define CRS_REF_HI             7
`define CRS_REF_LO             6
`define CRS_LEFT_ALIGN         5
`define CRS_RESERVED           4
`define CRS_CHAN_HI            3
`define CRS_CHAN_LO            0

// converter_control_status fields
`define CCS_ENABLE             7
`define CCS_START              6
`define CCS_AUTO_TRIG          5
`define CCS_DONE_FLAG          4
`define CCS_IRQ_ENABLE         3
`define CCS_DIV_HI             2
`define CCS_DIV_LO             0

`define CRS_RESET              8'h00
`define CCS_RESET              8'h00
`define TRIG_RESET             3'h0
`define CRS_WRITE_MASK         8'hef

// conversion lengths in converter clock cycles
`define FIRST_CONV_CYCLES      5'd25
`define NORMAL_CONV_CYCLES     5'd13
`define FREE_RUN_SOURCE        3'h0
`define CODE_BITS              10

`endif

//--- hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  typedef enum logic [1:0] {
    ref_external = 2'b00,
    ref_supply   = 2'b01,
    ref_reserved = 2'b10,
    ref_internal = 2'b11
  } reference_t;

  typedef enum logic [0:0] {
    conv_idle = 1'b0,
    conv_busy = 1'b1
  } conv_state_t;

  typedef struct packed {
    logic       start;
    logic [3:0] channel_select;
    logic [1:0] reference_select;
    logic       powered;
  } analog_ctrl_t;

  typedef struct packed {
    logic [7:0]  chan_ref;
    logic [3:0]  live_channel;
    logic [1:0]  live_reference;
    logic        enable;
    logic        start;
    logic        auto_trig;
    logic        done_flag;
    logic        irq_enable;
    logic [2:0]  divider;
    logic [2:0]  trig_source;
    logic [6:0]  prescale;
    logic        conv_tick;
    conv_state_t state;
    logic        first_pending;
    logic [4:0]  cycle_count;
    logic [9:0]  result;
    logic [9:0]  shown;
    logic        low_read_hold;
    logic        trig_prev;
    logic [7:0]  trig_s1;
    logic [7:0]  trig_s2;
    logic        core_start;
    logic [7:0]  read_data;
  } adc_state_t;

endpackage

//--- hw/adc_control_and_mux_select.sv
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"

module adc_control_and_mux_select (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic [2:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic [7:0]                      reg_rdata,
  input  wire logic [7:0]                 trigger_sources,
  input  wire logic                       global_irq_enable,
  input  wire logic                       irq_vector_ack,
  output logic                            conversion_irq,
  output adc_ctrl_pkg::analog_ctrl_t      analog_ctrl,
  input  wire logic [`CODE_BITS-1:0]      core_code,
  input  wire logic                       core_done
);
  import adc_ctrl_pkg::*;

  adc_state_t st;
  adc_state_t next_st;

  // prescale terminal count for a divider code; 000 and 001 both divide by 2
  function automatic logic [6:0] prescale_limit(input logic [2:0] code);
    logic [6:0] limit;
    unique case (code)
      3'h0: limit = 7'h01;
      3'h1: limit = 7'h01;
      3'h2: limit = 7'h03;
      3'h3: limit = 7'h07;
      3'h4: limit = 7'h0f;
      3'h5: limit = 7'h1f;
      3'h6: limit = 7'h3f;
      3'h7: limit = 7'h7f;
    endcase
    return limit;
  endfunction

  // conversion length in converter cycles; the first one also initialises the core
  function automatic logic [4:0] conv_length(input logic first);
    logic [4:0] n;
    if (first) begin
      n = `FIRST_CONV_CYCLES;
    end else begin
      n = `NORMAL_CONV_CYCLES;
    end
    return n;
  endfunction

  // free running: auto trigger on with source code zero
  function automatic logic is_free_run(input logic       auto_on,
                                       input logic [2:0] source);
    return auto_on && (source == `FREE_RUN_SOURCE);
  endfunction

  // high result byte: top eight bits when left aligned, else the top two
  function automatic logic [7:0] result_high(input logic [9:0] code,
                                             input logic       left);
    logic [7:0] b;
    if (left) begin
      b = code[9:2];
    end else begin
      b = {6'h00, code[9:8]};
    end
    return b;
  endfunction

  // low result byte: bottom two bits on top when left aligned, else eight
  function automatic logic [7:0] result_low(input logic [9:0] code,
                                            input logic       left);
    logic [7:0] b;
    if (left) begin
      b = {code[1:0], 6'h00};
    end else begin
      b = code[7:0];
    end
    return b;
  endfunction

  // control and status read word, each bit at its own field position
  function automatic logic [7:0] status_byte(input adc_state_t s);
    logic [7:0] b;
    b                          = 8'h00;
    b[`CCS_ENABLE]             = s.enable;
    b[`CCS_START]              = s.start;
    b[`CCS_AUTO_TRIG]          = s.auto_trig;
    b[`CCS_DONE_FLAG]          = s.done_flag;
    b[`CCS_IRQ_ENABLE]         = s.irq_enable;
    b[`CCS_DIV_HI:`CCS_DIV_LO] = s.divider;
    return b;
  endfunction

  // one register hit: the strobe together with an exact address match
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [2:0] addr,
                                   input logic [2:0] target);
    return strobe && (addr == target);
  endfunction

  // decoded strobes and per-cycle helpers of the sequencer
  logic        wr_crs;
  logic        wr_ccs;
  logic        wr_trig;
  logic        rd_low;
  logic        rd_high;
  logic        trig_level;
  logic        trig_rise;
  logic        want_start;
  logic        last_cycle;
  logic        conv_done;
  logic        free_running;
  logic [7:0]  shown_low;
  logic [7:0]  shown_high;
  logic [4:0]  conv_len;

  // register fields under their own names
  logic [3:0]  sel_channel;
  logic [1:0]  sel_reference;
  logic        sel_left_align;
  logic        w_enable;
  logic        w_start;
  logic        w_auto_trig;
  logic        w_flag_clear;
  logic        w_irq_enable;
  logic [2:0]  w_divider;

  // strobes decoded once against the address map
  assign wr_crs  = reg_hit(reg_write, reg_addr, `ADDR_CHAN_REF_SEL);
  assign wr_ccs  = reg_hit(reg_write, reg_addr, `ADDR_CTRL_STATUS);
  assign wr_trig = reg_hit(reg_write, reg_addr, `ADDR_TRIG_CONFIG);
  assign rd_low  = reg_hit(reg_read, reg_addr, `ADDR_RESULT_LOW);
  assign rd_high = reg_hit(reg_read, reg_addr, `ADDR_RESULT_HIGH);

  assign sel_channel    = st.chan_ref[`CRS_CHAN_HI:`CRS_CHAN_LO];
  assign sel_reference  = st.chan_ref[`CRS_REF_HI:`CRS_REF_LO];
  assign sel_left_align = st.chan_ref[`CRS_LEFT_ALIGN];
  assign w_enable       = reg_wdata[`CCS_ENABLE];
  assign w_start        = reg_wdata[`CCS_START];
  assign w_auto_trig    = reg_wdata[`CCS_AUTO_TRIG];
  assign w_flag_clear   = reg_wdata[`CCS_DONE_FLAG];
  assign w_irq_enable   = reg_wdata[`CCS_IRQ_ENABLE];
  assign w_divider      = reg_wdata[`CCS_DIV_HI:`CCS_DIV_LO];

  always_comb begin
    // defaults: every register holds, pulses fall back to zero
    next_st            = st;
    next_st.core_start = 1'b0;
    next_st.conv_tick  = 1'b0;
    next_st.read_data  = 8'h00;
    want_start         = 1'b0;

    // the data registers follow the alignment bit at once, even mid-conversion
    shown_low  = result_low(st.shown, sel_left_align);
    shown_high = result_high(st.shown, sel_left_align);

    // length and end of the running conversion
    conv_len     = conv_length(st.first_pending);
    last_cycle   = (st.state == conv_busy) && (st.cycle_count >= conv_len - 5'd1);
    conv_done    = last_cycle && st.conv_tick;
    free_running = is_free_run(st.auto_trig, st.trig_source);

    // every trigger bit passes two flops before the source mux reads it
    next_st.trig_s1   = trigger_sources;
    next_st.trig_s2   = st.trig_s1;
    trig_level        = st.trig_s2[st.trig_source];
    next_st.trig_prev = trig_level;
    trig_rise         = trig_level && !st.trig_prev;

    // register writes
    if (wr_crs) begin
      next_st.chan_ref = reg_wdata & `CRS_WRITE_MASK;
    end
    if (wr_trig) begin
      next_st.trig_source = reg_wdata[2:0];
      // seed with the new source's level so that a switch never fakes an edge
      next_st.trig_prev = st.trig_s2[reg_wdata[2:0]];
    end

    // selection follows the register only while idle or in the last cycle
    if (st.state == conv_idle || conv_done) begin
      next_st.live_channel   = sel_channel;
      next_st.live_reference = sel_reference;
    end

    // prescaler runs on the system clock; one-cycle tick per converter clock
    if (!st.enable) begin
      next_st.prescale = 7'h00;
    end else if (st.prescale >= prescale_limit(st.divider)) begin
      next_st.prescale  = 7'h00;
      next_st.conv_tick = 1'b1;
    end else begin
      next_st.prescale = st.prescale + 7'h01;
    end

    if (wr_ccs) begin
      if (!st.enable && w_enable) begin
        next_st.first_pending = 1'b1;
      end
      next_st.enable     = w_enable;
      next_st.auto_trig  = w_auto_trig;
      next_st.irq_enable = w_irq_enable;
      next_st.divider    = w_divider;
      // a zero in the start bit is never a stop request
      if (w_start) begin
        want_start = 1'b1;
      end
      // a one clears; software read-modify-write can drop a pending flag this way
      if (w_flag_clear) begin
        next_st.done_flag = 1'b0;
      end
    end

    // the interrupt vector acknowledge clears the flag as well
    if (irq_vector_ack) begin
      next_st.done_flag = 1'b0;
    end

    // a rising edge on the chosen source starts a conversion
    if (st.auto_trig && !free_running && trig_rise) begin
      want_start = 1'b1;
    end

    // conversion sequencer
    unique case (st.state)
      conv_idle: begin
        if (want_start && next_st.enable) begin
          next_st.start = 1'b1;
        end
        // conversions begin on a converter clock edge, never inside a period
        if (st.start && st.enable && st.conv_tick) begin
          next_st.state       = conv_busy;
          next_st.cycle_count = 5'd0;
          next_st.core_start  = 1'b1;
        end
      end
      conv_busy: begin
        if (st.conv_tick) begin
          next_st.cycle_count = st.cycle_count + 5'd1;
        end
        // the core may answer early; its code is kept until completion
        if (core_done) begin
          next_st.result = core_code;
        end
        if (conv_done) begin
          next_st.state         = conv_idle;
          next_st.first_pending = 1'b0;
          // the set comes after the clears above, so it wins a tie
          next_st.done_flag     = 1'b1;
          if (free_running) begin
            next_st.start = 1'b1;
          end else begin
            next_st.start = 1'b0;
          end
        end
      end
    endcase

    // a finished result is shown only if no low/high read pair is open
    if (!st.low_read_hold && conv_done) begin
      next_st.shown = next_st.result;
    end
    if (rd_low) begin
      next_st.low_read_hold = 1'b1;
    end
    if (rd_high) begin
      next_st.low_read_hold = 1'b0;
      next_st.shown         = next_st.result;
    end

    // clearing enable wins over start and sequencer state and drops a running conversion; a finish in the same cycle still sets the done flag
    if (!next_st.enable) begin
      next_st.state       = conv_idle;
      next_st.start       = 1'b0;
      next_st.cycle_count = 5'd0;
      next_st.core_start  = 1'b0;
    end

    // read data is registered and stands for the one cycle after the strobe
    if (reg_read) begin
      unique case (reg_addr)
        `ADDR_CHAN_REF_SEL: begin
          next_st.read_data = st.chan_ref;
        end
        `ADDR_CTRL_STATUS: begin
          next_st.read_data = status_byte(st);
        end
        `ADDR_RESULT_LOW: begin
          next_st.read_data = shown_low;
        end
        `ADDR_RESULT_HIGH: begin
          next_st.read_data = shown_high;
        end
        `ADDR_TRIG_CONFIG: begin
          next_st.read_data = {5'h00, st.trig_source};
        end
        default: begin
          // unmapped addresses read as zero
          next_st.read_data = 8'h00;
        end
      endcase
    end
  end

  // async reset clears every field, the done flag included
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // read data comes straight from a flop, zero outside its one cycle
  assign reg_rdata      = st.read_data;
  assign conversion_irq = st.done_flag && st.irq_enable && global_irq_enable;

  // the core sees selections only through the locked copies
  assign analog_ctrl.start            = st.core_start;
  assign analog_ctrl.channel_select   = st.live_channel;
  assign analog_ctrl.reference_select = st.live_reference;
  assign analog_ctrl.powered          = st.enable;

endmodule // adc_control_and_mux_select

//--- test/adc_props.sv
`timescale 1ns/1ps
module adc_props (
  input wire logic                       core_clk,
  input wire logic                       rst_n,
  input wire logic [2:0]                 reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic                       reg_write,
  input wire logic                       reg_read,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       global_irq_enable,
  input wire logic                       irq_vector_ack,
  input wire logic                       conversion_irq,
  input wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl
);
  import adc_ctrl_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire wr_ctl = reg_write && reg_addr == 3'h1;
  a_irq_gated: assert property (conversion_irq |-> global_irq_enable)
    else $error("irq without global enable");
  a_bit4_zero: assert property ($past(reg_read && reg_addr == 3'h0) |-> !reg_rdata[4])
    else $error("reserved bit reads one");
  a_start_powered: assert property (analog_ctrl.start |-> analog_ctrl.powered)
    else $error("start while unpowered");
  a_power_off: assert property (wr_ctl && !reg_wdata[7] |-> ##[1:2] !analog_ctrl.powered)
    else $error("power stays on");
  a_start_pulse: assert property (analog_ctrl.start |=> !analog_ctrl.start)
    else $error("start longer than a cycle");
  a_sel_locked: assert property (analog_ctrl.start |=>
    $stable({analog_ctrl.channel_select, analog_ctrl.reference_select})[*8])
    else $error("selection moved in conversion");
  a_zero_keeps: assert property (wr_ctl && reg_wdata[3] && !reg_wdata[4] && conversion_irq
    && !irq_vector_ack ##1 global_irq_enable |-> conversion_irq) else $error("flag lost");
  a_start_begins: assert property (wr_ctl && reg_wdata[7:6] == 2'b11
    && reg_wdata[2:1] == 2'b00 |-> ##[1:4] analog_ctrl.start) else $error("no start");
  c_start: cover property (analog_ctrl.start);
  c_irq: cover property (conversion_irq);
  c_ack: cover property (irq_vector_ack && conversion_irq);
endmodule // adc_props

bind adc_control_and_mux_select adc_props u_props (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
  .irq_vector_ack(irq_vector_ack), .conversion_irq(conversion_irq), .analog_ctrl(analog_ctrl));

//--- test/core_model.sv
`timescale 1ns/1ps
module core_model (
  input  wire logic                       core_clk,
  input  wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
  output logic [9:0]                      core_code,
  output logic                            core_done
);
  import adc_ctrl_pkg::*;
  logic [3:0] wait_count;
  logic [9:0] held;
  initial begin
    wait_count = 4'h0;
    core_code = 10'h000;
    core_done = 1'b0;
  end
  // code outside done toggles so a stale capture never matches
  always @(posedge core_clk) begin
    core_done <= 1'b0;
    core_code <= ~core_code;
    if (analog_ctrl.start && analog_ctrl.powered) begin
      wait_count <= 4'h4;
      held <= {analog_ctrl.reference_select, analog_ctrl.channel_select, 4'h9};
    end else if (wait_count != 4'h0) begin
      wait_count <= wait_count - 4'h1;
      if (wait_count == 4'h1) begin
        core_done <= 1'b1;
        core_code <= held;
      end
    end
  end
endmodule // core_model

//--- test/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module tb;
  import adc_ctrl_pkg::*;
  logic         core_clk, rst_n, reg_write, reg_read, global_irq_enable, irq_vector_ack;
  logic [2:0]   reg_addr;
  logic [7:0]   reg_wdata, reg_rdata, trigger_sources, d;
  logic         conversion_irq, core_done;
  logic [9:0]   core_code;
  analog_ctrl_t analog_ctrl;
  int           bad_count, total_checks, n, cycles, div;
  adc_control_and_mux_select dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .trigger_sources(trigger_sources), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .conversion_irq(conversion_irq),
    .analog_ctrl(analog_ctrl), .core_code(core_code), .core_done(core_done));
  core_model partner (.core_clk(core_clk), .analog_ctrl(analog_ctrl), .core_code(core_code),
    .core_done(core_done));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task test_done();
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [2:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task wait_irq(input int limit);
    n = 0;
    while (conversion_irq !== 1'b1 && n < limit) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task t_first();
    wr(3'h0, 8'hc6);
    wr(3'h1, 8'hc8);
    wait_irq(400);
    `CHK(n >= 44 && n <= 60, 1'b1)
    `CHK(analog_ctrl.channel_select, 4'h6)
    `CHK(analog_ctrl.reference_select, 2'b11)
    rd(3'h1);
    `CHK(d[6:4], 3'b001)
    rd(3'h2);
    `CHK(d, 8'h69)
    rd(3'h3);
    `CHK(d, 8'h03)
    wr(3'h0, 8'he6);
    rd(3'h3);
    `CHK(d, 8'hda)
    rd(3'h2);
    `CHK(d, 8'h40)
    wr(3'h1, 8'h88);
    `CHK(conversion_irq, 1'b1)
    global_irq_enable <= 1'b0;
    @(posedge core_clk);
    #1 `CHK(conversion_irq, 1'b0)
    @(posedge core_clk);
    global_irq_enable <= 1'b1;
    wr(3'h1, 8'h98);
    `CHK(conversion_irq, 1'b0)
  endtask
  task t_div();
    for (int c = 0; c < 8; c++) begin
      div = (c < 2) ? 2 : (1 << c);
      wr(3'h1, 8'hc8 | c[7:0]);
      wait_irq(3000);
      `CHK(n >= 12 * div - 2 && n <= 14 * div + 8, 1'b1)
      wr(3'h1, 8'h98 | c[7:0]);
    end
  endtask
  task t_hold();
    rd(3'h3);
    wr(3'h0, 8'hc6);
    wr(3'h1, 8'hc8);
    // let the start land first, a select written on that edge is ambiguous
    repeat (4) @(posedge core_clk);
    wr(3'h0, 8'h01);
    `CHK(analog_ctrl.channel_select, 4'h6)
    wait_irq(400);
    wr(3'h1, 8'h98);
    `CHK(analog_ctrl.channel_select, 4'h1)
    rd(3'h2);
    `CHK(d, 8'h69)
    wr(3'h1, 8'hc8);
    wait_irq(400);
    rd(3'h3);
    `CHK(d, 8'h03)
    rd(3'h2);
    `CHK(d, 8'h19)
    rd(3'h3);
    `CHK(d, 8'h00)
    wr(3'h1, 8'h98);
  endtask
  task t_abort();
    wr(3'h1, 8'hc8);
    repeat (12) @(posedge core_clk);
    wr(3'h1, 8'h08);
    `CHK(analog_ctrl.powered, 1'b0)
    wait_irq(100);
    `CHK(conversion_irq, 1'b0)
    rd(3'h1);
    `CHK(d[6], 1'b0)
    rd(3'h6);
    `CHK(d, 8'h00)
  endtask
  task t_auto();
    wr(3'h4, 8'h00);
    wr(3'h1, 8'he8);
    wait_irq(400);
    wr(3'h1, 8'hb8);
    wait_irq(100);
    `CHK(conversion_irq, 1'b1)
    wr(3'h1, 8'h18);
    wr(3'h4, 8'h02);
    wr(3'h1, 8'hb8);
    wait_irq(80);
    `CHK(conversion_irq, 1'b0)
    trigger_sources <= 8'h04;
    wait_irq(200);
    `CHK(conversion_irq, 1'b1)
    trigger_sources <= 8'h00;
    irq_vector_ack <= 1'b1;
    @(posedge core_clk);
    irq_vector_ack <= 1'b0;
    @(posedge core_clk);
    #1 `CHK(conversion_irq, 1'b0)
  endtask
  initial begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    trigger_sources = 8'h00;
    global_irq_enable = 1'b1;
    irq_vector_ack = 1'b0;
    repeat (10) @(posedge core_clk);
    `CHK(analog_ctrl, 8'h00)
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(3'h1);
    `CHK(d, 8'h00)
    wr(3'h0, 8'hff);
    rd(3'h0);
    `CHK(d, 8'hef)
    t_first();
    t_div();
    t_hold();
    t_abort();
    t_auto();
    test_done();
  end
endmodule // tb
